// *** stam_pkg.sv ***
// package: constants and types for the supply/temperature monitor
// How it works
// - one 12-bit successive-approximation converter digitises both the supply voltage and the die temperature, each result readable by software.
// - every supply result is also handed to the limiter and brownout guard as a strobed word.
// - conversions run at a fixed 667 kHz, 1.5 us each, alternating temperature then supply from reset.
// - each quantity therefore gets a fresh result every 3 us, 333 kHz per channel.
// - a result appears before the end of its own 1.5 us conversion period, at most 4.5 us after an input change.
// - the supply code reads as volts times 256, 0x000 is 0 V and 0xE00 is 14 V.
// - the temperature code reads as (code / 16) - 93 degrees, so 0x000 is -93 C and 0xfff is 162.9375 C.
package stam_pkg;
    localparam int unsigned CLK_HZ       = 50_000_000;
    localparam int unsigned CONV_NS      = 1500;
    localparam int unsigned CONV_CYC     = (CONV_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int unsigned RES_W        = 12;
    localparam int unsigned SAR_STEP_CYC = CONV_CYC / (RES_W + 1);
    localparam logic [11:0] CODE_ZERO    = 12'h000;
    localparam logic [11:0] VOLT_14V     = 12'he00;
    localparam logic [11:0] TEMP_MAX     = 12'hfff;
    localparam int unsigned VOLT_DIV     = 256;
    localparam int unsigned TEMP_DIV     = 16;
    localparam int unsigned TEMP_OFS     = 93;

    typedef enum logic [1:0] {
        STAM_CH_SUPPLY = 2'b01,
        STAM_CH_TEMP   = 2'b10
    } stam_chan_e;

    typedef struct packed {
        logic        valid;
        logic [11:0] code;
    } stam_result_s;
endpackage

// *** stam_sar.sv ***
// one 12-bit successive-approximation conversion engine
`timescale 1ns/1ps
module stam_sar #(
    parameter int unsigned WIDTH = stam_pkg::RES_W
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             start,
    input  wire logic             step,
    input  wire logic             cmp_above,
    output logic [WIDTH-1:0]      trial,
    output logic                  done,
    output logic [WIDTH-1:0]      code
);
    import stam_pkg::*;

    logic [WIDTH-1:0] acc;
    logic [WIDTH-1:0] bitp;
    logic [WIDTH-1:0] next_acc;
    logic [WIDTH-1:0] next_bitp;
    logic [WIDTH-1:0] next_code;
    logic             next_done;

    assign trial = acc | bitp;

    // binary search, one bit per step, msb first
    always_comb begin
        next_acc  = acc;
        next_bitp = bitp;
        next_code = code;
        next_done = 1'b0;
        if (start) begin
            next_acc  = '0;
            next_bitp = {1'b1, {(WIDTH-1){1'b0}}};
        end else if (step && bitp != '0) begin
            next_acc  = cmp_above ? (acc | bitp) : acc;
            next_bitp = bitp >> 1;
            if (bitp[0]) begin
                next_code = cmp_above ? (acc | bitp) : acc;
                next_done = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            acc  <= '0;
            bitp <= '0;
            code <= '0;
            done <= 1'b0;
        end else begin
            acc  <= next_acc;
            bitp <= next_bitp;
            code <= next_code;
            done <= next_done;
        end
    end
endmodule

// *** stam_monitor.sv ***
// supply voltage and die temperature monitor top level
`timescale 1ns/1ps
module stam_monitor (
    input  wire logic                 mclk,
    input  wire logic                 rst,
    input  wire logic                 supply_above,
    input  wire logic                 temp_above,
    output logic [11:0]               dac_trial,
    output stam_pkg::stam_chan_e      chan_sel,
    output logic [11:0]               supply_voltage_code,
    output logic [11:0]               die_temp_code,
    output stam_pkg::stam_result_s    guard_result
);
    import stam_pkg::*;

    localparam int unsigned CW = $clog2(CONV_CYC);
    localparam int unsigned SW = $clog2(SAR_STEP_CYC + 1);
    localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYC - 1);
    localparam logic [SW-1:0] STEP_LAST = SW'(SAR_STEP_CYC - 1);

    logic [CW-1:0] conv_cnt;
    logic [CW-1:0] next_conv_cnt;
    logic [SW-1:0] step_cnt;
    logic [SW-1:0] next_step_cnt;
    stam_chan_e    next_chan;
    logic          sup_s1, sup_s2, tmp_s1, tmp_s2;
    logic          start;
    logic          step;
    logic          done;
    logic [11:0]   code;
    logic [11:0]   next_supply;
    logic [11:0]   next_temp;
    stam_result_s  next_guard;

    // comparator pins are asynchronous to mclk
    always_ff @(posedge mclk) begin
        if (rst) begin
            sup_s1 <= 1'b0;
            sup_s2 <= 1'b0;
            tmp_s1 <= 1'b0;
            tmp_s2 <= 1'b0;
        end else begin
            sup_s1 <= supply_above;
            sup_s2 <= sup_s1;
            tmp_s1 <= temp_above;
            tmp_s2 <= tmp_s1;
        end
    end

    // fixed 1.5 us frame, channel swaps each frame
    always_comb begin
        start         = (conv_cnt == CONV_LAST);
        next_conv_cnt = start ? '0 : conv_cnt + CW'(1);
        next_chan     = chan_sel;
        if (start) begin
            next_chan = (chan_sel == STAM_CH_SUPPLY) ? STAM_CH_TEMP
                                                     : STAM_CH_SUPPLY;
        end
        step          = (step_cnt == STEP_LAST);
        next_step_cnt = (start || step) ? '0 : step_cnt + SW'(1);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            conv_cnt  <= '0;
            step_cnt  <= '0;
            chan_sel  <= STAM_CH_SUPPLY;
        end else begin
            conv_cnt  <= next_conv_cnt;
            step_cnt  <= next_step_cnt;
            chan_sel  <= next_chan;
        end
    end

    stam_sar #(.WIDTH(RES_W)) u_sar (
        .mclk      (mclk),
        .rst       (rst),
        .start     (start),
        .step      (step),
        .cmp_above (chan_sel == STAM_CH_SUPPLY ? sup_s2 : tmp_s2),
        .trial     (dac_trial),
        .done      (done),
        .code      (code)
    );

    // whole-word update of the owning register
    // supply code is volts*256, temp code is (degC+93)*16
    always_comb begin
        next_supply = supply_voltage_code;
        next_temp   = die_temp_code;
        next_guard  = '{valid: 1'b0, code: guard_result.code};
        if (done && chan_sel == STAM_CH_SUPPLY) begin
            next_supply = code;
            next_guard  = '{valid: 1'b1, code: code};
        end
        if (done && chan_sel == STAM_CH_TEMP) begin
            next_temp = code;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            supply_voltage_code <= CODE_ZERO;
            die_temp_code       <= CODE_ZERO;
            guard_result        <= '{valid: 1'b0, code: CODE_ZERO};
        end else begin
            supply_voltage_code <= next_supply;
            die_temp_code       <= next_temp;
            guard_result        <= next_guard;
        end
    end

    // guard strobe once per two frames
    int unsigned gap;
    logic        gap_armed;
    always_ff @(posedge mclk) begin
        if (rst || guard_result.valid) begin
            gap <= 0;
        end else if (gap < 1000) begin
            gap <= gap + 1;
        end
    end

    // first strobe comes late after reset, so the bound waits for it
    always_ff @(posedge mclk) begin
        if (rst) begin
            gap_armed <= 1'b0;
        end else if (guard_result.valid) begin
            gap_armed <= 1'b1;
        end
    end

    property p_guard_period;
        @(posedge mclk) disable iff (rst)
        guard_result.valid |-> ##150 guard_result.valid;
    endproperty
    a_guard_period: assert property (p_guard_period)
        else $error("supply result not every 3 us");

    property p_guard_single;
        @(posedge mclk) disable iff (rst)
        guard_result.valid |=> !guard_result.valid [*8];
    endproperty
    a_guard_single: assert property (p_guard_single)
        else $error("supply strobe longer than one cycle");

    property p_guard_matches;
        @(posedge mclk) disable iff (rst)
        guard_result.valid |-> guard_result.code == supply_voltage_code;
    endproperty
    a_guard_matches: assert property (p_guard_matches)
        else $error("guard word differs from supply register");

    property p_chan_alternate;
        @(posedge mclk) disable iff (rst)
        start |=> chan_sel != $past(chan_sel);
    endproperty
    a_chan_alternate: assert property (p_chan_alternate)
        else $error("channel did not alternate");

    property p_frame_len;
        @(posedge mclk) disable iff (rst)
        start |-> ##75 start;
    endproperty
    a_frame_len: assert property (p_frame_len)
        else $error("conversion frame not 1.5 us");

    property p_done_in_frame;
        @(posedge mclk) disable iff (rst)
        start |-> ##[1:74] done;
    endproperty
    a_done_in_frame: assert property (p_done_in_frame)
        else $error("conversion not done within its frame");

    property p_temp_stable;
        @(posedge mclk) disable iff (rst)
        chan_sel == STAM_CH_SUPPLY && !start |=> $stable(die_temp_code);
    endproperty
    a_temp_stable: assert property (p_temp_stable)
        else $error("temperature changed during supply frame");

    property p_supply_stable;
        @(posedge mclk) disable iff (rst)
        !guard_result.valid |-> $stable(supply_voltage_code);
    endproperty
    a_supply_stable: assert property (p_supply_stable)
        else $error("supply changed without a strobe");

    property p_gap_bound;
        @(posedge mclk) disable iff (rst)
        gap_armed |-> gap <= 150;
    endproperty
    a_gap_bound: assert property (p_gap_bound)
        else $error("supply result older than 3 us");

    property p_temp_load;
        @(posedge mclk) disable iff (rst)
        done && chan_sel == STAM_CH_TEMP
            |=> die_temp_code == $past(code);
    endproperty
    a_temp_load: assert property (p_temp_load)
        else $error("temperature register missed its result");

    property p_supply_load;
        @(posedge mclk) disable iff (rst)
        done && chan_sel == STAM_CH_SUPPLY
            |=> supply_voltage_code == $past(code);
    endproperty
    a_supply_load: assert property (p_supply_load)
        else $error("supply register missed its result");

    property p_trial_msb;
        @(posedge mclk) disable iff (rst)
        start |=> dac_trial == 12'h800;
    endproperty
    a_trial_msb: assert property (p_trial_msb)
        else $error("conversion did not start at the top bit");

    property p_done_pulse;
        @(posedge mclk) disable iff (rst)
        done |=> !done;
    endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("done held longer than one cycle");

    property p_chan_onehot;
        @(posedge mclk) disable iff (rst)
        chan_sel == STAM_CH_SUPPLY || chan_sel == STAM_CH_TEMP;
    endproperty
    a_chan_onehot: assert property (p_chan_onehot)
        else $error("channel select not one-hot");
endmodule

// *** stam_analog_model.sv ***
// comparator model of the supply rail and the die temperature sensor
`timescale 1ns/1ps
module stam_analog_model (
    input  wire logic                mclk,
    input  wire logic [11:0]         supply_level,
    input  wire logic [11:0]         temp_level,
    input  wire logic [11:0]         dac_trial,
    input  wire stam_pkg::stam_chan_e chan_sel,
    output logic                     supply_above,
    output logic                     temp_above
);
    import stam_pkg::*;
    logic idle_pat = 1'b0;

    // unselected comparator chatters every cycle
    always @(posedge mclk) begin
        idle_pat <= ~idle_pat;
    end

    // level sits half a count above its code
    assign supply_above = (chan_sel == STAM_CH_SUPPLY) ?
        (supply_level >= dac_trial) : idle_pat;
    assign temp_above = (chan_sel == STAM_CH_TEMP) ?
        (temp_level >= dac_trial) : ~idle_pat;
endmodule

// *** stam_monitor_test.sv ***
// self-checking bench for the supply and temperature monitor
`timescale 1ns/1ps
module stam_monitor_test;
    import stam_pkg::*;
    logic          mclk         = 1'b0;
    logic          rst          = 1'b1;
    logic [11:0]   supply_level = 12'he00;
    logic [11:0]   temp_level   = 12'h760;
    logic          supply_above;
    logic          temp_above;
    logic [11:0]   dac_trial;
    logic [11:0]   supply_voltage_code;
    logic [11:0]   die_temp_code;
    stam_chan_e    chan_sel;
    stam_chan_e    c0;
    stam_result_s  guard_result;
    int            bad_count    = 0;
    int            checked      = 0;
    int            cyc          = 0;
    int            t0;
    int            t1;
    logic [11:0]   sup_tab [3]  = '{12'hc9a, 12'h000, 12'hfff};
    logic [11:0]   tmp_tab [3]  = '{12'hfff, 12'h000, 12'h001};

    stam_monitor dut_u (
        .mclk                (mclk),
        .rst                 (rst),
        .supply_above        (supply_above),
        .temp_above          (temp_above),
        .dac_trial           (dac_trial),
        .chan_sel            (chan_sel),
        .supply_voltage_code (supply_voltage_code),
        .die_temp_code       (die_temp_code),
        .guard_result        (guard_result)
    );

    stam_analog_model model_u (
        .mclk         (mclk),
        .supply_level (supply_level),
        .temp_level   (temp_level),
        .dac_trial    (dac_trial),
        .chan_sel     (chan_sel),
        .supply_above (supply_above),
        .temp_above   (temp_above)
    );

    always #10 mclk = ~mclk;

    always @(posedge mclk) begin
        cyc <= cyc + 1;
    end

    task automatic conclude();
        $display("mismatches %0d comparisons %0d", bad_count, checked);
        if (bad_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check_code(input string name, input logic [11:0] exp,
                              input logic [11:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_num(input string name, input int exp, input int got);
        checked++;
        if (got != exp) begin
            bad_count++;
            $display("ERROR %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    task automatic tick();
        @(posedge mclk);
        #1;
    endtask

    // bounded wait for the next guard strobe
    task automatic wait_valid(output int t);
        int n;
        tick();
        for (n = 0; n < 400 && guard_result.valid !== 1'b1; n++) begin
            tick();
        end
        if (n == 400) begin
            bad_count++;
            $display("ERROR guard valid expected 1 seen timeout");
            conclude();
        end
        t = cyc;
    endtask

    // bounded wait for both codes, then hold check
    task automatic wait_codes(input logic [11:0] s, input logic [11:0] t);
        int n;
        n = 0;
        while (n < 226 && (supply_voltage_code !== s
                           || die_temp_code !== t)) begin
            tick();
            n++;
        end
        check_num("update within 225 cycles", 1, int'(n <= 225));
        check_code("supply code", s, supply_voltage_code);
        check_code("temp code", t, die_temp_code);
        for (n = 0; n < 150; n++) begin
            tick();
            check_code("supply held", s, supply_voltage_code);
            check_code("temp held", t, die_temp_code);
        end
    endtask

    initial begin
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        wait_valid(t0);
        check_code("guard code", 12'he00, guard_result.code);
        check_code("supply readback", 12'he00, supply_voltage_code);
        wait_valid(t1);
        check_num("supply result period", 150, t1 - t0);
        check_code("temp readback", 12'h760, die_temp_code);
        for (int i = 0; i < 6; i++) begin
            c0 = chan_sel;
            repeat (75) tick();
            check_code("channel select", {10'h000, c0[0], c0[1]},
                       {10'h000, chan_sel});
        end
        for (int i = 0; i < 3; i++) begin
            @(negedge mclk);
            supply_level = sup_tab[i];
            temp_level = tmp_tab[i];
            wait_codes(sup_tab[i], tmp_tab[i]);
        end
        // mid-run reset, then the converter must restart on its own
        @(negedge mclk);
        rst = 1'b1;
        tick();
        check_code("reset supply", CODE_ZERO, supply_voltage_code);
        check_code("reset temp", CODE_ZERO, die_temp_code);
        check_code("reset channel", {10'h000, STAM_CH_SUPPLY},
                   {10'h000, chan_sel});
        check_code("reset guard valid", 12'h000,
                   {11'h000, guard_result.valid});
        repeat (4) tick();
        @(negedge mclk);
        rst = 1'b0;
        wait_valid(t0);
        check_code("guard after reset", 12'hfff, guard_result.code);
        conclude();
    end
endmodule
